// *** src/ebt_map.svh ***
// Constants and field positions for the external bus phase timer
`ifndef EBT_MAP_SVH
`define EBT_MAP_SVH
`define EBT_NUM_CS 4
`define EBT_REG_CFG0 8'h00
`define EBT_REG_STATUS 8'h10
`define EBT_REG_DIV 8'h14
`define EBT_F_AB_LSB 0
`define EBT_F_AB_EXT_LSB 1
`define EBT_F_C_LSB 3
`define EBT_F_D_LSB 5
`define EBT_F_E_LSB 6
`define EBT_F_F_LSB 11
`define EBT_CFG_RESET 13'h1fff
`define EBT_DIV_RESET 8'h00
`define EBT_CFG_W 13
`endif

// *** src/ebt_pkg.sv ***
// Types for the external bus phase timer
package ebt_pkg;
  typedef enum logic [2:0] {
    EBT_IDLE,
    EBT_AB,
    EBT_C,
    EBT_D,
    EBT_E,
    EBT_F
  } ebt_phase_t;
endpackage : ebt_pkg

// *** src/ebt_tick_div.sv ***
// Bus clock period divider producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module ebt_tick_div (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [7:0] i_div,
  output logic o_tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  always_comb begin
    cnt_next = (cnt_reg >= i_div) ? 8'h00 : cnt_reg + 8'h01;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_tick = (cnt_reg >= i_div);
endmodule : ebt_tick_div
`default_nettype wire

// *** src/ebt_phase_timer.sv ***
// External bus cycle phase sequencer with per chip select timing
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ebt_map.svh"
module ebt_phase_timer
  import ebt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_req,
  input wire logic [1:0] i_cs,
  output logic o_ack,
  output logic o_busy,
  output logic [2:0] o_phase,
  output logic o_tick,
  output logic o_done
);
  logic [`EBT_CFG_W-1:0] cfg_reg [`EBT_NUM_CS];
  logic [`EBT_CFG_W-1:0] cfg_next [`EBT_NUM_CS];
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  ebt_phase_t phase_reg;
  ebt_phase_t phase_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [1:0] cs_reg;
  logic [1:0] cs_next;
  logic [1:0] last_cs_reg;
  logic [1:0] last_cs_next;
  logic first_reg;
  logic first_next;
  logic done_reg;
  logic done_next;
  logic tick;
  logic [`EBT_CFG_W-1:0] cfg;

  // Period length of a phase from the selected timing word
  function automatic logic [5:0] phase_len(
    input ebt_phase_t ph,
    input logic [`EBT_CFG_W-1:0] c,
    input logic win_change
  );
    logic [5:0] n;
    n = 6'h00;
    case (ph)
      EBT_AB: begin
        n = {5'h00, c[`EBT_F_AB_LSB]} + 6'h01;
        if (win_change) begin
          n = n + {4'h0, c[`EBT_F_AB_EXT_LSB +: 2]};
        end
      end
      EBT_C: n = {4'h0, c[`EBT_F_C_LSB +: 2]};
      EBT_D: n = {5'h00, c[`EBT_F_D_LSB]};
      EBT_E: n = {1'b0, c[`EBT_F_E_LSB +: 5]} + 6'h01;
      EBT_F: n = {4'h0, c[`EBT_F_F_LSB +: 2]};
      default: n = 6'h00;
    endcase
    return n;
  endfunction : phase_len

  // Next phase in the fixed order, skipping empty ones
  function automatic ebt_phase_t after(
    input ebt_phase_t ph,
    input logic [`EBT_CFG_W-1:0] c
  );
    ebt_phase_t p;
    p = ph;
    case (ph)
      EBT_AB: p = EBT_C;
      EBT_C: p = EBT_D;
      EBT_D: p = EBT_E;
      EBT_E: p = EBT_F;
      default: p = EBT_IDLE;
    endcase
    if (p == EBT_C && phase_len(EBT_C, c, 1'b0) == 6'h00) begin
      p = EBT_D;
    end
    if (p == EBT_D && phase_len(EBT_D, c, 1'b0) == 6'h00) begin
      p = EBT_E;
    end
    if (p == EBT_F && phase_len(EBT_F, c, 1'b0) == 6'h00) begin
      p = EBT_IDLE;
    end
    return p;
  endfunction : after

  ebt_tick_div u_div (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_div(div_reg),
    .o_tick(tick)
  );

  assign cfg = cfg_reg[cs_reg];

  // Register file
  always_comb begin
    cfg_next = cfg_reg;
    div_next = div_reg;
    rdata_next = 32'h0000_0000;
    if (i_wr) begin
      if (i_addr[7:4] == 4'h0 && i_addr[1:0] == 2'b00) begin
        cfg_next[i_addr[3:2]] = i_wdata[`EBT_CFG_W-1:0];
      end else if (i_addr == `EBT_REG_DIV) begin
        div_next = i_wdata[7:0];
      end
    end
    if (i_rd) begin
      if (i_addr[7:4] == 4'h0 && i_addr[1:0] == 2'b00) begin
        rdata_next = {19'h00000, cfg_reg[i_addr[3:2]]};
      end else if (i_addr == `EBT_REG_STATUS) begin
        rdata_next = {20'h00000, last_cs_reg, cnt_reg, 1'b0, phase_reg};
      end else if (i_addr == `EBT_REG_DIV) begin
        rdata_next = {24'h000000, div_reg};
      end
    end
  end

  // Phase sequencer; one count step per bus clock period
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    cs_next = cs_reg;
    last_cs_next = last_cs_reg;
    first_next = first_reg;
    done_next = 1'b0;
    case (phase_reg)
      EBT_IDLE: begin
        if (i_req && tick) begin
          cs_next = i_cs;
          phase_next = EBT_AB;
          cnt_next = phase_len(EBT_AB, cfg_reg[i_cs],
                               first_reg || (i_cs != last_cs_reg));
          last_cs_next = i_cs;
          first_next = 1'b0;
        end
      end
      EBT_AB, EBT_C, EBT_D, EBT_E, EBT_F: begin
        if (tick) begin
          if (cnt_reg > 6'h01) begin
            cnt_next = cnt_reg - 6'h01;
          end else begin
            phase_next = after(phase_reg, cfg);
            cnt_next = phase_len(after(phase_reg, cfg), cfg, 1'b0);
            done_next = (after(phase_reg, cfg) == EBT_IDLE);
          end
        end
      end
      default: begin
        phase_next = EBT_IDLE;
        cnt_next = 6'h00;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `EBT_NUM_CS; i++) begin
        cfg_reg[i] <= `EBT_CFG_RESET;
      end
      div_reg <= `EBT_DIV_RESET;
      rdata_reg <= 32'h0000_0000;
      phase_reg <= EBT_IDLE;
      cnt_reg <= 6'h00;
      cs_reg <= 2'h0;
      last_cs_reg <= 2'h0;
      first_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      div_reg <= div_next;
      rdata_reg <= rdata_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      cs_reg <= cs_next;
      last_cs_reg <= last_cs_next;
      first_reg <= first_next;
      done_reg <= done_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_ack = (phase_reg == EBT_IDLE) && i_req && tick;
  assign o_busy = (phase_reg != EBT_IDLE);
  assign o_phase = phase_reg;
  assign o_tick = tick;
  assign o_done = done_reg;
endmodule : ebt_phase_timer
`default_nettype wire

// *** testbench/ebt_phase_checker_assertions.sv ***
// Port-level checker for the bus phase timer
`timescale 1ns/1ps
`default_nettype none
module ebt_phase_checker (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic o_ack,
  input wire logic o_busy,
  input wire logic [2:0] o_phase,
  input wire logic o_tick,
  input wire logic o_done
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  ack_idle_a: assert property (
    o_ack |-> i_req && o_tick && o_phase == 3'h0) else $error("bad ack");
  ab_first_a: assert property (
    o_ack |=> o_phase == 3'h1) else $error("no setup");
  phase_up_a: assert property (
    o_phase != $past(o_phase) |-> o_phase > $past(o_phase) ||
    o_phase == 3'h0) else $error("phase order");
  tick_step_a: assert property (
    o_phase != $past(o_phase) |-> $past(o_tick)) else $error("no tick");
  done_end_a: assert property (
    $fell(o_busy) |-> o_done) else $error("no done");
  ab_max_a: assert property (
    (o_phase == 3'h1 && o_tick) [*5] |=> o_phase != 3'h1)
    else $error("setup long");
  cmd_max_a: assert property (
    (o_phase == 3'h2 && o_tick) [*3] |=> o_phase != 3'h2)
    else $error("delay long");
  wsetup_max_a: assert property (
    o_phase == 3'h3 && o_tick |=> o_phase != 3'h3) else $error("d long");
  hold_max_a: assert property (
    (o_phase == 3'h5 && o_tick) [*3] |=> o_phase != 3'h5)
    else $error("hold long");
  cover property (o_phase == 3'h2);
  cover property (o_phase == 3'h3);
  cover property (o_phase == 3'h5);
endmodule : ebt_phase_checker
bind ebt_phase_timer ebt_phase_checker i_chk (.i_mclk, .i_nrst, .i_req,
  .o_ack, .o_busy, .o_phase, .o_tick, .o_done);
`default_nettype wire

// *** testbench/ebt_far_model.sv ***
// Requester side model: holds a request until it is taken
`timescale 1ns/1ps
`default_nettype none
module ebt_far_model (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [1:0] i_cs_sel,
  input wire logic i_ack,
  output logic o_req,
  output logic [1:0] o_cs
);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_req <= 1'b0;
      o_cs <= 2'h0;
    end else if (i_ack) begin
      o_req <= 1'b0;
    end else if (i_start) begin
      o_req <= 1'b1;
      o_cs <= i_cs_sel;
    end
  end
endmodule : ebt_far_model
`default_nettype wire

// *** testbench/ebt_phase_timer_test.sv ***
// Self-checking bench for the bus phase timer
`timescale 1ns/1ps
`default_nettype none
module ebt_phase_timer_test;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic wr = 1'b0, rd = 1'b0, start = 1'b0, req, ack, busy, done, tick;
  logic [1:0] cs_sel = 2'h0, cs;
  logic [2:0] phase;
  int fails = 0, num_checks = 0;
  ebt_phase_timer i_dut (.i_mclk, .i_nrst, .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_req(req), .i_cs(cs),
    .o_ack(ack), .o_busy(busy), .o_phase(phase), .o_tick(tick),
    .o_done(done));
  ebt_far_model i_far (.i_mclk, .i_nrst, .i_start(start),
    .i_cs_sel(cs_sel), .i_ack(ack), .o_req(req), .o_cs(cs));
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  // Busy cycles equal the summed phase lengths while ticks run every cycle
  task automatic acc(input logic [1:0] c, input logic [31:0] cfg,
                     input logic [31:0] e);
    logic [31:0] n;
    n = 0;
    wr_reg({4'h0, c, 2'h0}, cfg);
    @(posedge i_mclk);
    start <= 1'b1;
    cs_sel <= c;
    @(posedge i_mclk);
    start <= 1'b0;
    repeat (200) begin
      @(posedge i_mclk);
      #1;
      if (done === 1'b1) break;
      if (busy === 1'b1) n = n + 1;
    end
    chk(n, e);
  endtask : acc
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd_chk(8'h00, 32'h1fff);
    rd_chk(8'h20, 32'h0);
    wr_reg(8'h14, 32'h0);
    acc(2'h0, 32'h0, 32'd2);
    acc(2'h0, 32'h1fff, 32'd41);
    acc(2'h1, 32'h1fff, 32'd44);
    acc(2'h1, 32'h0, 32'd2);
    acc(2'h2, 32'h0821, 32'd5);
    rd_chk(8'h08, 32'h0821);
    rd_chk(8'h10, 32'h0800);
    wr_reg(8'h14, 32'h1);
    rd_chk(8'h14, 32'h1);
    acc(2'h2, 32'h0, 32'd4);
    tally_and_finish();
  end
endmodule : ebt_phase_timer_test
`default_nettype wire
